// [shared/rsfe_params.svh]
`ifndef RSFE_PARAMS_SVH
`define RSFE_PARAMS_SVH
// Register byte offsets
`define RSFE_OFF_CTRL 4'h0
`define RSFE_OFF_CMD 4'h4
`define RSFE_OFF_STAT 4'h8
// Control fields and reset value: address 01, rate 9600, no parity, one stop
`define RSFE_F_ADDR_LSB 0
`define RSFE_F_BAUD_LSB 8
`define RSFE_F_PAR_LSB 12
`define RSFE_F_TWO_STOP 14
`define RSFE_CTRL_RST 15'h0501
// Command bits
`define RSFE_CMD_ENTER 0
`define RSFE_CMD_LEAVE 1
// Status fields
`define RSFE_S_CFG 0
`define RSFE_S_ACT 1
`define RSFE_S_DEF 2
`define RSFE_S_TX 3
`define RSFE_S_COIL_LSB 8
// Clock in hertz, rates in baud
`define RSFE_CLK_HZ 100000000
`define RSFE_BAUD_300 300
`define RSFE_BAUD_600 600
`define RSFE_BAUD_1200 1200
`define RSFE_BAUD_2400 2400
`define RSFE_BAUD_4800 4800
`define RSFE_BAUD_9600 9600
`define RSFE_BAUD_19200 19200
`define RSFE_BAUD_38400 38400
`define RSFE_BAUD_57600 57600
`define RSFE_BAUD_115200 115200
// Silent intervals in tenths of a character, character length in bits
`define RSFE_CHAR_BITS 11
`define RSFE_T15_TENTHS 15
`define RSFE_T35_TENTHS 35
// Function and exception codes
`define RSFE_FN_RD_COIL 8'h01
`define RSFE_FN_RD_INREG 8'h04
`define RSFE_FN_WR_COIL 8'h05
`define RSFE_FN_WR_REG 8'h06
`define RSFE_FN_WR_COILS 8'h0f
`define RSFE_EXC_FUNC 8'h01
`define RSFE_EXC_ADDR 8'h02
`define RSFE_EXC_VALUE 8'h03
`define RSFE_EXC_FLAG 8'h80
// Check field, largest register and coil counts
`define RSFE_CRC_INIT 16'hffff
`define RSFE_CRC_POLY 16'ha001
`define RSFE_MAX_REGS 16
`define RSFE_MAX_COILS 8
`endif

// [shared/rsfe_pkg.sv]
package rsfe_pkg;
  typedef enum logic {RSFE_ST_RX, RSFE_ST_TX} rsfe_state_t;
  typedef struct packed {
    rsfe_state_t state;
    logic rx_s1;
    logic rx_s2;
    logic def_s1;
    logic def_s2;
    logic def_prev;
    logic [19:0] div;
    logic rx_busy;
    logic rx_new;
    logic [4:0] rx_ph;
    logic [10:0] rx_sh;
    logic [6:0] sil;
    logic f_on;
    logic f_err;
    logic [7:0] f_n;
    logic [15:0] f_crc;
    logic [7:0][7:0] frm;
    logic tx_busy;
    logic [4:0] tx_ph;
    logic [11:0] tx_sh;
    logic [7:0] tx_idx;
    logic [7:0] tx_len;
    logic [15:0] tx_crc;
    logic [7:0] exc;
    logic leave_pend;
    logic rtu_cfg;
    logic rtu_act;
    logic [14:0] ctrl;
    logic [7:0] coil;
    logic ser_tx;
    logic ser_en;
    logic [31:0] rd;
  } rsfe_st_t;
endpackage

// [verilog/rsfe_frame_engine.sv]
// Contract
// - Characters are start bit, eight data bits, parity slot and stop bit; with no parity and one stop bit the engine uses ten bits and no slot.
// - Even or odd parity; without parity one or two stop bits.
// - Ten selectable rates from 300 up to 115200 baud.
// - Message bytes are raw binary octets, never hex text.
// - First byte is the slave address; answer only our own address.
// - Second byte is the function code, then data, then check field.
// - Register reads carry a zero-based start register after the function.
// - Next two bytes give the register count including the first.
// - Last two bytes are a CRC over all preceding bytes.
// - No prompts or terminators; bytes go out back to back.
// - Silence of 3.5 characters ends the current message.
// - A byte after more than 1.5 characters idle starts a new message.
// - Replies begin with the echoed address and function code.
// - Register read replies carry a byte count after the function.
// - Each returned register takes two data bytes.
// - The slave transmits only in answer to a request.
// - Requests that cannot be served get an exception reply with a code.
// - Functions 01, 04, 05, 06 and 15 are served; others are unsupported.
// - Start in native mode; enter and leave commands switch RTU mode.
// - While the default pin is grounded use 300 baud, no parity.
// - Releasing the default pin resets the engine and restores configured mode.
// - Register values go out high byte first.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`include "rsfe_params.svh"
module rsfe_frame_engine
  import rsfe_pkg::*;
#(
  parameter int CLK_HZ = `RSFE_CLK_HZ
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic ser_rx,
  output logic ser_tx,
  output logic ser_tx_en,
  input wire logic default_n,
  input wire logic [15:0] ain_value,
  input wire logic [7:0] din_value,
  output logic [7:0] coil_out,
  output logic rtu_active
);
  localparam logic [6:0] T15H = 7'(`RSFE_T15_TENTHS * `RSFE_CHAR_BITS / 5);
  localparam logic [6:0] T35H = 7'(`RSFE_T35_TENTHS * `RSFE_CHAR_BITS / 5);

  rsfe_st_t s;
  rsfe_st_t n;
  logic def_low;
  logic release_ev;
  logic [19:0] half;
  logic par_on;
  logic par_odd;
  logic [4:0] nbits;
  logic tick;
  logic start_edge;
  logic rx_done;
  logic [10:0] rx_new_sh;
  logic [10:0] rx_v;
  logic rx_err;
  logic frame_end;
  logic frame_go;
  logic [15:0] st;
  logic [15:0] cnt;
  logic [16:0] span;
  logic [7:0] exc_d;
  logic [7:0] len_d;
  logic tx_load;
  logic [7:0] tx_b;
  logic [7:0] k;
  logic [15:0] reg_val;
  logic [15:0] coil_w;
  logic [7:0] fn;

  function automatic logic [15:0] rsfe_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ `RSFE_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Half-bit period per rate select; each case is a constant so no divider is built
  function automatic logic [19:0] rsfe_half(input logic [3:0] sel);
    case (sel)
      4'h0: rsfe_half = 20'(CLK_HZ / `RSFE_BAUD_300 / 2);
      4'h1: rsfe_half = 20'(CLK_HZ / `RSFE_BAUD_600 / 2);
      4'h2: rsfe_half = 20'(CLK_HZ / `RSFE_BAUD_1200 / 2);
      4'h3: rsfe_half = 20'(CLK_HZ / `RSFE_BAUD_2400 / 2);
      4'h4: rsfe_half = 20'(CLK_HZ / `RSFE_BAUD_4800 / 2);
      4'h6: rsfe_half = 20'(CLK_HZ / `RSFE_BAUD_19200 / 2);
      4'h7: rsfe_half = 20'(CLK_HZ / `RSFE_BAUD_38400 / 2);
      4'h8: rsfe_half = 20'(CLK_HZ / `RSFE_BAUD_57600 / 2);
      4'h9: rsfe_half = 20'(CLK_HZ / `RSFE_BAUD_115200 / 2);
      default: rsfe_half = 20'(CLK_HZ / `RSFE_BAUD_9600 / 2);
    endcase
  endfunction

  always_comb
  begin
    n = s;
    def_low = ~s.def_s2;
    release_ev = s.def_s2 & ~s.def_prev;
    // Grounded default pin overrides the stored line settings
    half = def_low ? rsfe_half(4'h0) : rsfe_half(s.ctrl[`RSFE_F_BAUD_LSB +: 4]);
    par_on = ~def_low & (s.ctrl[`RSFE_F_PAR_LSB +: 2] != 2'h0);
    par_odd = s.ctrl[`RSFE_F_PAR_LSB + 1];
    nbits = (par_on | (~def_low & s.ctrl[`RSFE_F_TWO_STOP])) ? 5'd11 : 5'd10;
    tick = (s.div >= half - 20'h00001);
    start_edge = (s.state == RSFE_ST_RX) & s.rtu_act & ~s.rx_busy & ~s.rx_s2;
    fn = s.frm[1];
    st = {s.frm[2], s.frm[3]};
    cnt = {s.frm[4], s.frm[5]};
    span = {1'b0, st} + {1'b0, cnt};
    k = s.tx_idx - 8'h03;
    n.rx_s1 = ser_rx;
    n.rx_s2 = s.rx_s1;
    n.def_s1 = default_n;
    n.def_s2 = s.def_s1;
    n.def_prev = s.def_s2;

    // Register port
    n.rd = 32'h0;
    if (bus_rd)
    begin
      if (bus_addr == `RSFE_OFF_CTRL)
        n.rd = {17'h0, s.ctrl};
      else if (bus_addr == `RSFE_OFF_STAT)
        n.rd = {16'h0, s.coil, 4'h0, (s.state == RSFE_ST_TX), def_low, s.rtu_act, s.rtu_cfg};
    end
    if (bus_wr)
    begin
      if (bus_addr == `RSFE_OFF_CTRL)
        n.ctrl = bus_wdata[14:0];
      else if (bus_addr == `RSFE_OFF_CMD)
      begin
        if (bus_wdata[`RSFE_CMD_ENTER])
        begin
          n.rtu_cfg = 1'b1;
          n.rtu_act = 1'b1;
        end
        if (bus_wdata[`RSFE_CMD_LEAVE])
        begin
          n.rtu_cfg = 1'b0;
          n.rtu_act = 1'b0;
        end
      end
    end

    // Half-bit timebase, realigned to each start edge and each transmitted byte
    tx_load = (s.state == RSFE_ST_TX) & ~s.tx_busy & (s.tx_idx != s.tx_len);
    n.div = (tick | start_edge | tx_load) ? 20'h0 : s.div + 20'h00001;

    // Receiver: sample at the middle of each bit
    rx_done = 1'b0;
    rx_new_sh = {s.rx_s2, s.rx_sh[10:1]};
    rx_v = (nbits == 5'd11) ? rx_new_sh : {1'b1, rx_new_sh[10:1]};
    rx_err = (rx_v[0] != 1'b0) | (rx_v[10] != 1'b1) |
             (par_on ? (rx_v[9] != (^rx_v[8:1] ^ par_odd)) : (rx_v[9] != 1'b1));
    if (start_edge)
    begin
      n.rx_busy = 1'b1;
      n.rx_ph = 5'h0;
      n.sil = 7'h0;
      n.rx_new = (s.sil > T15H) | ~s.f_on;
    end
    else if (s.rx_busy & tick)
    begin
      n.rx_ph = s.rx_ph + 5'h01;
      if (~s.rx_ph[0])
      begin
        n.rx_sh = rx_new_sh;
        if (s.rx_ph[4:1] == 4'(nbits - 5'd1))
        begin
          n.rx_busy = 1'b0;
          rx_done = 1'b1;
        end
      end
    end
    else if (~s.rx_busy & tick & (s.sil != 7'h7f))
      n.sil = s.sil + 7'h01;

    // Bytes are kept raw; the running CRC over a good frame including its check field ends at zero
    if (rx_done)
    begin
      if (s.rx_new)
      begin
        n.f_on = 1'b1;
        n.f_n = 8'h01;
        n.f_err = rx_err;
        n.f_crc = rsfe_crc(`RSFE_CRC_INIT, rx_v[8:1]);
        n.frm[0] = rx_v[8:1];
      end
      else
      begin
        n.f_n = (s.f_n == 8'hff) ? s.f_n : s.f_n + 8'h01;
        n.f_err = s.f_err | rx_err;
        n.f_crc = rsfe_crc(s.f_crc, rx_v[8:1]);
        if (s.f_n < 8'h08)
          n.frm[s.f_n[2:0]] = rx_v[8:1];
      end
    end

    // Request check at end of frame
    frame_end = (s.state == RSFE_ST_RX) & s.f_on & ~s.rx_busy & ~start_edge & (s.sil >= T35H);
    frame_go = frame_end & ~s.f_err & (s.f_n >= 8'h04) & (s.f_crc == 16'h0) &
               (s.frm[0] == s.ctrl[`RSFE_F_ADDR_LSB +: 8]) & (s.frm[0] != 8'h00);
    exc_d = 8'h00;
    case (fn)
      `RSFE_FN_RD_COIL, `RSFE_FN_RD_INREG:
      begin
        if ((cnt == 16'h0) | (cnt > 16'(`RSFE_MAX_REGS)))
          exc_d = `RSFE_EXC_VALUE;
        else if (span > 17'(`RSFE_MAX_REGS))
          exc_d = `RSFE_EXC_ADDR;
      end
      `RSFE_FN_WR_COIL:
      begin
        if (st >= 16'(`RSFE_MAX_COILS))
          exc_d = `RSFE_EXC_ADDR;
        else if ((cnt != 16'hff00) & (cnt != 16'h0000))
          exc_d = `RSFE_EXC_VALUE;
      end
      `RSFE_FN_WR_REG:
      begin
        if (st != 16'h0)
          exc_d = `RSFE_EXC_ADDR;
        else if (cnt != 16'h0)
          exc_d = `RSFE_EXC_VALUE;
      end
      `RSFE_FN_WR_COILS:
      begin
        if ((cnt == 16'h0) | (cnt > 16'(`RSFE_MAX_COILS)) | (s.f_n < 8'h0a))
          exc_d = `RSFE_EXC_VALUE;
        else if (span > 17'(`RSFE_MAX_COILS))
          exc_d = `RSFE_EXC_ADDR;
      end
      default: exc_d = `RSFE_EXC_FUNC;
    endcase
    if (exc_d != 8'h00)
      len_d = 8'h05;
    else if (fn == `RSFE_FN_RD_INREG)
      len_d = 8'h05 + {cnt[6:0], 1'b0};
    else if (fn == `RSFE_FN_RD_COIL)
      len_d = (cnt > 16'h0008) ? 8'h07 : 8'h06;
    else
      len_d = 8'h08;

    if (frame_end)
    begin
      n.f_on = 1'b0;
      if (frame_go)
      begin
        n.state = RSFE_ST_TX;
        n.exc = exc_d;
        n.tx_len = len_d;
        n.tx_idx = 8'h00;
        n.tx_crc = `RSFE_CRC_INIT;
        n.tx_busy = 1'b0;
        n.ser_en = 1'b1;
        if (exc_d == 8'h00)
        begin
          if (fn == `RSFE_FN_WR_COIL)
            n.coil[st[2:0]] = cnt[15];
          else if (fn == `RSFE_FN_WR_COILS)
          begin
            for (int i = 0; i < 8; i++)
            begin
              if ((i >= st) & (i < span))
                n.coil[i] = s.frm[7][3'(i - st)];
            end
          end
          else if (fn == `RSFE_FN_WR_REG)
            n.leave_pend = 1'b1;
        end
      end
    end

    // Reply byte for the current index
    reg_val = ({8'h00, s.frm[3]} + {9'h0, k[7:1]} == 16'h0) ? ain_value : 16'h0;
    coil_w = ({din_value, s.coil} >> st) & ~(16'hffff << cnt[4:0]);
    if (s.tx_idx == s.tx_len - 8'h02)
      tx_b = s.tx_crc[7:0];
    else if (s.tx_idx == s.tx_len - 8'h01)
      tx_b = s.tx_crc[15:8];
    else if (s.tx_idx == 8'h00)
      tx_b = s.frm[0];
    else if (s.tx_idx == 8'h01)
      tx_b = (s.exc != 8'h00) ? (fn | `RSFE_EXC_FLAG) : fn;
    else if (s.exc != 8'h00)
      tx_b = s.exc;
    else if (fn == `RSFE_FN_RD_INREG)
    begin
      if (s.tx_idx == 8'h02)
        tx_b = {cnt[6:0], 1'b0};
      else
        tx_b = k[0] ? reg_val[7:0] : reg_val[15:8];
    end
    else if (fn == `RSFE_FN_RD_COIL)
    begin
      if (s.tx_idx == 8'h02)
        tx_b = (cnt > 16'h0008) ? 8'h02 : 8'h01;
      else
        tx_b = k[0] ? coil_w[15:8] : coil_w[7:0];
    end
    else
      tx_b = s.frm[s.tx_idx[2:0]];

    // Transmitter: bytes follow each other with no idle between stop and start
    if (s.state == RSFE_ST_TX)
    begin
      if (tx_load)
      begin
        n.tx_busy = 1'b1;
        n.tx_ph = 5'h0;
        n.tx_sh = {2'b11, par_on ? (^tx_b ^ par_odd) : 1'b1, tx_b, 1'b0};
        n.ser_tx = 1'b0;
        if (s.tx_idx < s.tx_len - 8'h02)
          n.tx_crc = rsfe_crc(s.tx_crc, tx_b);
      end
      else if (s.tx_busy & tick)
      begin
        n.tx_ph = s.tx_ph + 5'h01;
        if (s.tx_ph[0])
        begin
          n.tx_sh = {1'b1, s.tx_sh[11:1]};
          n.ser_tx = s.tx_sh[1];
          if (s.tx_ph[4:1] == 4'(nbits - 5'd1))
          begin
            n.tx_busy = 1'b0;
            n.ser_tx = 1'b1;
            n.tx_idx = s.tx_idx + 8'h01;
          end
        end
      end
      else if (~s.tx_busy)
      begin
        n.state = RSFE_ST_RX;
        n.ser_en = 1'b0;
        if (s.leave_pend)
        begin
          n.rtu_act = 1'b0;
          n.leave_pend = 1'b0;
        end
      end
    end

    // Releasing the default pin restarts the engine in the configured mode
    if (release_ev)
    begin
      n.state = RSFE_ST_RX;
      n.rx_busy = 1'b0;
      n.f_on = 1'b0;
      n.tx_busy = 1'b0;
      n.ser_en = 1'b0;
      n.ser_tx = 1'b1;
      n.leave_pend = 1'b0;
      n.rtu_act = s.rtu_cfg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.rx_s1 <= 1'b1;
      s.rx_s2 <= 1'b1;
      s.def_s1 <= 1'b1;
      s.def_s2 <= 1'b1;
      s.def_prev <= 1'b1;
      s.ctrl <= `RSFE_CTRL_RST;
      s.ser_tx <= 1'b1;
    end
    else
      s <= n;
  end

  assign bus_rdata = s.rd;
  assign ser_tx = s.ser_tx;
  assign ser_tx_en = s.ser_en;
  assign coil_out = s.coil;
  assign rtu_active = s.rtu_act;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_byte_load;
    tx_load;
  endsequence
  sequence s_reply_start;
    frame_go ##1 (s.state == RSFE_ST_TX);
  endsequence

  a_tx_only_reply: assert property ($rose(s.ser_en) |-> $past(frame_go))
    else $error("transmitter enabled without a valid request");
  a_bad_crc_drop: assert property ((frame_end && s.f_crc != 16'h0) |=> (s.state == RSFE_ST_RX))
    else $error("frame with bad check answered");
  a_addr_match: assert property (s_reply_start |-> (s.frm[0] == s.ctrl[7:0]))
    else $error("reply to a foreign address");
  a_new_frame: assert property ((rx_done && s.rx_new && !release_ev) |=> (s.f_n == 8'h01))
    else $error("new frame not started after long idle");
  a_end_silence: assert property ((frame_end && !release_ev) |=> !s.f_on)
    else $error("frame not closed after silence");
  a_default_rate: assert property (def_low |-> (half == 20'(CLK_HZ / 600) && !par_on))
    else $error("default pin does not force 300 baud no parity");
  a_start_bit: assert property ((s_byte_load and !release_ev) |=> (!s.ser_tx && s.tx_busy))
    else $error("byte does not open with a start bit");
  a_echo_addr: assert property ((s_byte_load and (s.tx_idx == 8'h00)) |-> (tx_b == s.frm[0]))
    else $error("reply does not echo the address");
  a_exc_flag: assert property ((tx_load && s.tx_idx == 8'h01 && s.exc != 8'h00) |-> tx_b == (s.frm[1] | 8'h80))
    else $error("exception reply lacks flagged function");
  a_unsup_fn: assert property ((frame_go && !(fn inside {8'h01, 8'h04, 8'h05, 8'h06, 8'h0f})) |=> s.exc == 8'h01)
    else $error("unsupported function not refused");
  a_leave_cmd: assert property ((bus_wr && bus_addr == 4'h4 && bus_wdata[1] && !release_ev) |=> !s.rtu_act)
    else $error("leave command did not stop the engine");
  a_release_mode: assert property (release_ev |=> (s.rtu_act == $past(s.rtu_cfg)) && (s.state == RSFE_ST_RX))
    else $error("default pin release did not restore mode");
endmodule

// [verif/rsfe_master_model.sv]
`timescale 1ns/1ns
module rsfe_master_model #(
  parameter int BIT = 10
)
(
  input wire logic clk,
  output logic ser_rx,
  input wire logic ser_tx,
  input wire logic ser_tx_en,
  input wire logic par_on,
  input wire logic par_odd,
  input wire logic two_stop
);
  logic [7:0] got[$];
  int par_bad = 0;

  // Line is biased to mark between frames, so idle is driven high
  initial ser_rx = 1'b1;

  task automatic put_bit(input logic b);
    @(posedge clk);
    ser_rx <= b;
    repeat (BIT - 1) @(posedge clk);
  endtask

  task automatic send_byte(input logic [7:0] b);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++)
      put_bit(b[i]);
    if (par_on)
      put_bit(^b ^ par_odd);
    put_bit(1'b1);
    if (two_stop)
      put_bit(1'b1);
  endtask

  // Only ever called by the bench, so the slave never sees an unasked request
  task automatic send(input logic [7:0] q[$], input int gap);
    repeat (gap) @(posedge clk);
    foreach (q[i])
      send_byte(q[i]);
  endtask

  initial
  begin
    logic [7:0] b;
    forever
    begin
      @(posedge clk);
      if (ser_tx_en === 1'b1 && ser_tx === 1'b0)
      begin
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT) @(posedge clk);
          b[i] = ser_tx;
        end
        if (par_on)
        begin
          repeat (BIT) @(posedge clk);
          if (ser_tx !== (^b ^ par_odd))
            par_bad++;
        end
        // Stops at mid stop bit so the next start edge is not missed
        repeat (BIT) @(posedge clk);
        got.push_back(b);
      end
    end
  end
endmodule

// [verif/rsfe_frame_engine_tb.sv]
`timescale 1ns/1ns
module rsfe_frame_engine_tb
  import rsfe_pkg::*;
;
  typedef logic [7:0] rsfe_bq_t[$];
  localparam int BIT = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_rdata;
  logic ser_rx;
  logic ser_tx;
  logic ser_tx_en;
  logic default_n;
  logic [15:0] ain_value;
  logic [7:0] din_value;
  logic [7:0] coil_out;
  logic rtu_active;
  logic par_on;
  logic par_odd;
  logic two_stop;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] rnd = 32'h8e33;
  rsfe_bq_t none;

  always #5 clk = ~clk;

  // Slow clock parameter keeps one bit at exactly BIT cycles at 115200 baud
  rsfe_frame_engine #(.CLK_HZ(1152000)) uut (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .ser_rx(ser_rx), .ser_tx(ser_tx), .ser_tx_en(ser_tx_en), .default_n(default_n),
    .ain_value(ain_value), .din_value(din_value), .coil_out(coil_out), .rtu_active(rtu_active));

  rsfe_master_model #(.BIT(BIT)) m (.clk(clk), .ser_rx(ser_rx), .ser_tx(ser_tx),
    .ser_tx_en(ser_tx_en), .par_on(par_on), .par_odd(par_odd), .two_stop(two_stop));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic rsfe_bq_t with_crc(input rsfe_bq_t q);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    return q;
  endfunction

  function automatic rsfe_bq_t req(input logic [7:0] a, input logic [7:0] f, input logic [15:0] w1,
    input logic [15:0] w2);
    return with_crc('{a, f, w1[15:8], w1[7:0], w2[15:8], w2[7:0]});
  endfunction

  function automatic rsfe_bq_t exc(input logic [7:0] a, input logic [7:0] f, input logic [7:0] c);
    return with_crc('{a, f | 8'h80, c});
  endfunction

  task automatic final_report;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fails++;
      final_report;
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_q(input rsfe_bq_t got, input rsfe_bq_t exp);
    chk32(got.size(), exp.size());
    foreach (exp[i])
      if (i < got.size())
        chk32({24'h0, got[i]}, {24'h0, exp[i]});
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    chk32(bus_rdata, exp);
  endtask

  // Sends one request, waits for the reply to finish and compares its bytes
  task automatic xact(input rsfe_bq_t q, input rsfe_bq_t exp, input int gap = 0);
    int n;
    m.got.delete();
    m.send(q, gap);
    n = 0;
    while (ser_tx_en !== 1'b1 && n < 1500)
    begin
      @(posedge clk);
      n++;
    end
    while (ser_tx_en === 1'b1 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    chk_q(m.got, exp);
  endtask

  initial
  begin
    logic [7:0] r;
    logic [7:0] bad[5];
    rsfe_bq_t q;
    bad = '{8'h02, 8'h03, 8'h07, 8'h10, 8'h2b};
    bus_addr = 4'h0;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    default_n = 1'b1;
    ain_value = 16'h0;
    din_value = 8'h0;
    par_on = 1'b0;
    par_odd = 1'b0;
    two_stop = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rchk(4'h0, 32'h0000_0501);
    rchk(4'h8, 32'h0);
    rchk(4'hc, 32'h0);
    xact(req(8'h01, 8'h04, 16'h0, 16'h1), none);
    wr(4'h4, 32'h1);
    wr(4'h0, 32'h0911);
    rchk(4'h8, 32'h3);
    rchk(4'h0, 32'h0911);
    for (int n = 1; n <= 2; n++)
    begin
      rnd = lfsr(rnd);
      @(posedge clk);
      ain_value <= rnd[15:0];
      q = '{8'h11, 8'h04, 8'(2 * n), rnd[15:8], rnd[7:0]};
      if (n == 2)
        q = '{8'h11, 8'h04, 8'h04, rnd[15:8], rnd[7:0], 8'h00, 8'h00};
      xact(req(8'h11, 8'h04, 16'h0, 16'(n)), with_crc(q));
    end
    foreach (bad[i])
      xact(req(8'h11, bad[i], 16'h0, 16'h1), exc(8'h11, bad[i], 8'h01));
    xact(req(8'h11, 8'h04, 16'd15, 16'd2), exc(8'h11, 8'h04, 8'h02));
    xact(req(8'h11, 8'h04, 16'h0, 16'h0), exc(8'h11, 8'h04, 8'h03));
    xact(req(8'h11, 8'h01, 16'h0, 16'd17), exc(8'h11, 8'h01, 8'h03));
    xact(req(8'h11, 8'h05, 16'h3, 16'hff00), req(8'h11, 8'h05, 16'h3, 16'hff00));
    chk32({24'h0, coil_out}, 32'h08);
    xact(req(8'h11, 8'h05, 16'h8, 16'hff00), exc(8'h11, 8'h05, 8'h02));
    xact(req(8'h11, 8'h05, 16'h1, 16'h1234), exc(8'h11, 8'h05, 8'h03));
    rnd = lfsr(rnd);
    r = rnd[7:0];
    q = with_crc('{8'h11, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h08, 8'h01, r});
    xact(q, req(8'h11, 8'h0f, 16'h0, 16'h8));
    chk32({24'h0, coil_out}, {24'h0, r});
    @(posedge clk);
    din_value <= rnd[15:8];
    xact(req(8'h11, 8'h01, 16'h0, 16'd16), with_crc('{8'h11, 8'h01, 8'h02, r, rnd[15:8]}));
    xact(req(8'h12, 8'h04, 16'h0, 16'h1), none);
    q = req(8'h11, 8'h04, 16'h0, 16'h1);
    q[7] = q[7] ^ 8'h01;
    xact(q, none);
    q = req(8'h11, 8'h04, 16'h0, 16'h1);
    m.send(q[0:3], 0);
    xact(q[4:7], none, 40 * BIT);
    m.send('{8'h11, 8'h04, 8'h00}, 0);
    xact(q, with_crc('{8'h11, 8'h04, 8'h02, ain_value[15:8], ain_value[7:0]}), 20 * BIT);
    // Even parity, odd parity, then no parity with two stop bits
    for (int p = 1; p <= 3; p++)
    begin
      wr(4'h0, (p == 3) ? 32'h4911 : 32'h0911 | (p << 12));
      par_on <= (p != 3);
      par_odd <= (p == 2);
      two_stop <= (p == 3);
      xact(q, with_crc('{8'h11, 8'h04, 8'h02, ain_value[15:8], ain_value[7:0]}));
    end
    chk32(m.par_bad, 32'h0);
    wr(4'h0, 32'h0911);
    par_on <= 1'b0;
    two_stop <= 1'b0;
    xact(req(8'h11, 8'h06, 16'h1, 16'h0), exc(8'h11, 8'h06, 8'h02));
    xact(req(8'h11, 8'h06, 16'h0, 16'h5), exc(8'h11, 8'h06, 8'h03));
    xact(req(8'h11, 8'h06, 16'h0, 16'h0), req(8'h11, 8'h06, 16'h0, 16'h0));
    repeat (4) @(posedge clk);
    chk32({31'h0, rtu_active}, 32'h0);
    rchk(4'h8, {16'h0, r, 8'h01});
    @(posedge clk);
    default_n <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(4'h8, {16'h0, r, 8'h05});
    @(posedge clk);
    default_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk32({31'h0, rtu_active}, 32'h1);
    wr(4'h4, 32'h2);
    repeat (2) @(posedge clk);
    chk32({31'h0, rtu_active}, 32'h0);
    final_report;
  end
endmodule
